/* hw/sdram_pin_command_interface.sv */
// How it works
// RULE1: Every pin is registered on ref_clk.
// RULE2: Low clock enable suspends, powers down or self-refreshes.
// RULE3: Power-down exit watches the raw clock enable.
// RULE4: Input capture stops while powered down.
// RULE5: High chip select masks the command.
// RULE6: Bursts and masking continue under high chip select.
// RULE7: Strobes plus chip select encode the command.
// RULE8: Write mask high blocks that write data.
// RULE9: Read mask floats outputs two clocks later.
// RULE10: Low mask governs byte 0 on x16 only.
// RULE11: Bank inputs target activate, access and precharge.
// RULE12: Full address is the row on activate.
// RULE13: Column bits depend on the organisation.
// RULE14: Select bit asks auto precharge on access.
// RULE15: Select bit high precharges every bank.
// RULE16: Address carries the mode word on load.
// RULE17: Data bus width follows the organisation.
// RULE18: Controller activates a row before accessing it.
// RULE19: Burst lengths 1, 2, 4, 8, page, terminable.
// RULE20: Controller idles with chip select high or no-op.
`timescale 1ns/10ps
module sdram_pin_command_interface #(
  parameter int DQ_W = sdram_pkg::DQ_X16
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic data_mask_low_byte,
  input wire logic data_mask_high_byte,
  input wire logic [sdram_pkg::BA_W-1:0] ba,
  input wire logic [sdram_pkg::ADDR_W-1:0] addr,
  input wire logic [DQ_W-1:0] dq_in,
  output logic [DQ_W-1:0] dq_out,
  output logic [DQ_W-1:0] dq_oe,
  input wire logic [DQ_W-1:0] array_rd_data,
  output sdram_pkg::pwr_t power_state,
  output logic input_buf_en,
  output logic act_pulse,
  output logic pre_pulse,
  output logic pre_all,
  output logic refresh_pulse,
  output logic auto_pre_pulse,
  output logic [sdram_pkg::BA_W-1:0] bank_sel,
  output logic [sdram_pkg::ADDR_W-1:0] row_addr,
  output logic [sdram_pkg::COL_W_X4-1:0] col_addr,
  output logic [sdram_pkg::ADDR_W-1:0] mode_word,
  output logic array_wr_en,
  output logic [DQ_W-1:0] array_wr_data,
  output logic [DQ_W-1:0] array_wr_mask,
  output logic array_rd_en
);
  import sdram_pkg::*;

  localparam int COL_W = col_width(DQ_W);

  // ==========================================================================
  // Pin capture
  pins_t pins_reg, pins_next;
  logic [DQ_W-1:0] dq_reg, dq_next;
  logic cke_reg, cke_next;
  pwr_t pwr_reg, pwr_next;
  logic buf_on;

  // Input buffers are off in power-down and self refresh; the raw clock
  // enable alone reopens them on the exit edge.
  assign buf_on = (pwr_reg == PWR_RUN) || (pwr_reg == PWR_SUSPEND) || cke; // RULE3

  always_comb begin
    pins_next = pins_reg;
    dq_next = dq_reg;
    cke_next = cke;
    if (buf_on) begin // RULE4
      pins_next = '{cs_n: cs_n, ras_n: ras_n, cas_n: cas_n, we_n: we_n, dml: data_mask_low_byte,
                    dmh: data_mask_high_byte, ba: ba, addr: addr}; // RULE1
      dq_next = dq_in;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pins_reg <= PINS_RST;
      dq_reg <= '0;
      // Reset counts as enabled so that leaving reset never looks like a power-down request.
      cke_reg <= 1'b1;
    end else begin
      pins_reg <= pins_next;
      dq_reg <= dq_next;
      cke_reg <= cke_next;
    end
  end

  // ==========================================================================
  // Decode
  cmd_t cmd;
  logic go;
  logic [DQ_W-1:0] dm_bits;
  logic [COL_W-1:0] col_now;

  assign cmd = pins_reg.cs_n ? CMD_NOP : cmd_t'({pins_reg.ras_n, pins_reg.cas_n, pins_reg.we_n}); // RULE5 RULE7
  // The internal clock only runs while the registered clock enable is high.
  assign go = cke_reg && ((pwr_reg == PWR_RUN) || (pwr_reg == PWR_SUSPEND)); // RULE2

  generate
    for (genvar i = 0; i < DQ_W; i++) begin : g_mask
      if (DQ_W == DQ_X16 && i < LOW_BYTE_W) begin : g_low
        assign dm_bits[i] = pins_reg.dml; // RULE10
      end else begin : g_high
        assign dm_bits[i] = pins_reg.dmh; // RULE10
      end
    end
  endgenerate

  generate
    if (DQ_W == DQ_X4) begin : g_col_x4
      assign col_now = COL_W'({pins_reg.addr[COL_TOP_BIT_X4], pins_reg.addr[COL_W_X8-1:0]}); // RULE13
    end else begin : g_col_other
      assign col_now = pins_reg.addr[COL_W-1:0]; // RULE13
    end
  endgenerate

  // ==========================================================================
  // Burst length from the mode word
  logic [ADDR_W-1:0] mode_reg, mode_next;
  logic [COL_W-1:0] limit;
  logic page;

  always_comb begin
    page = 1'b0;
    limit = '0;
    unique case (mode_reg[MODE_BL_LSB +: 3]) // RULE19
      BL_2: limit = COL_W'(1);
      BL_4: limit = COL_W'(3);
      BL_8: limit = COL_W'(7);
      BL_PAGE: page = 1'b1;
      default: limit = '0;
    endcase
  end

  // ==========================================================================
  // Burst sequencing
  logic load, stop, busy, xfer, is_rd, last, ap_cur;
  logic [COL_W-1:0] beat, beat_cur, base_cur, lmask, col_cur;
  logic [BA_W-1:0] bank_cur;
  logic rd_reg, rd_next, ap_reg, ap_next;
  logic [COL_W-1:0] base_reg, base_next;
  logic [BA_W-1:0] bank_reg, bank_next;

  assign load = go && ((cmd == CMD_RD) || (cmd == CMD_WR)); // RULE11
  assign stop = go && (cmd == CMD_BST); // RULE19

  sdram_burst_ctr #(
    .COL_W(COL_W)
  ) u_ctr (
    .ref_clk(ref_clk),
    .rst(rst),
    .load(load),
    .advance(go),
    .stop(stop),
    .page(page),
    .limit(limit),
    .busy(busy),
    .beat(beat)
  );

  // A burst keeps moving whatever chip select does.
  assign xfer = go && (load || busy) && !stop; // RULE6
  assign is_rd = load ? (cmd == CMD_RD) : rd_reg;
  assign beat_cur = load ? '0 : beat;
  assign base_cur = load ? col_now : base_reg;
  assign bank_cur = load ? pins_reg.ba : bank_reg;
  assign ap_cur = load ? pins_reg.addr[PRECHARGE_SELECT_BIT] : ap_reg; // RULE14
  // Fixed bursts wrap inside their aligned block; a page burst wraps the row.
  assign lmask = page ? '1 : limit;
  assign col_cur = (base_cur & ~lmask) | (COL_W'(base_cur + beat_cur) & lmask);
  assign last = xfer && !page && (beat_cur == limit);

  always_comb begin
    rd_next = rd_reg;
    ap_next = ap_reg;
    base_next = base_reg;
    bank_next = bank_reg;
    if (load) begin
      rd_next = is_rd;
      ap_next = ap_cur;
      base_next = col_now;
      bank_next = pins_reg.ba;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rd_reg <= 1'b0;
      ap_reg <= 1'b0;
      base_reg <= '0;
      bank_reg <= '0;
    end else begin
      rd_reg <= rd_next;
      ap_reg <= ap_next;
      base_reg <= base_next;
      bank_reg <= bank_next;
    end
  end

  // ==========================================================================
  // Power state
  always_comb begin
    pwr_next = pwr_reg;
    unique case (pwr_reg)
      PWR_RUN: begin
        if (!cke_reg) begin // RULE2
          if (cmd == CMD_REF && !busy) begin
            pwr_next = PWR_SELFREF;
          end else if (busy) begin
            pwr_next = PWR_SUSPEND;
          end else begin
            pwr_next = PWR_DOWN;
          end
        end
      end
      PWR_SUSPEND: begin
        if (cke_reg) begin
          pwr_next = PWR_RUN;
        end
      end
      PWR_DOWN, PWR_SELFREF: begin
        if (cke) begin // RULE3
          pwr_next = PWR_RUN;
        end
      end
    endcase
  end

  // ==========================================================================
  // Outputs
  logic buf_reg, buf_next;
  logic act_reg, act_next, pre_reg, pre_next, all_reg, all_next;
  logic ref_reg, ref_next, apl_reg, apl_next;
  logic [BA_W-1:0] bsel_reg, bsel_next;
  logic [ADDR_W-1:0] row_reg, row_next;
  logic [COL_W-1:0] col_reg, col_next;
  logic wen_reg, wen_next, ren_reg, ren_next;
  logic [DQ_W-1:0] wdat_reg, wdat_next, wmsk_reg, wmsk_next;
  logic [DQ_W-1:0] mdly_reg, mdly_next, dqo_reg, dqo_next, oe_reg, oe_next;

  always_comb begin
    buf_next = (pwr_next == PWR_RUN) || (pwr_next == PWR_SUSPEND); // RULE4
    act_next = go && (cmd == CMD_ACT);
    pre_next = go && (cmd == CMD_PRE);
    ref_next = go && (cmd == CMD_REF) && !busy;
    apl_next = last && ap_cur; // RULE14
    all_next = all_reg;
    bsel_next = bsel_reg;
    row_next = row_reg;
    mode_next = mode_reg;
    col_next = col_reg;
    wen_next = xfer && !is_rd;
    ren_next = xfer && is_rd;
    wdat_next = wdat_reg;
    wmsk_next = wmsk_reg;
    mdly_next = dm_bits; // RULE6
    dqo_next = ren_reg ? array_rd_data : dqo_reg; // RULE1
    // The mask seen one clock earlier gates the outputs on the following edge.
    oe_next = {DQ_W{ren_reg}} & ~mdly_reg; // RULE9 RULE17
    if (act_next) begin
      bsel_next = pins_reg.ba; // RULE11
      row_next = pins_reg.addr; // RULE12
    end
    if (pre_next) begin
      bsel_next = pins_reg.ba;
      all_next = pins_reg.addr[PRECHARGE_SELECT_BIT]; // RULE15
    end
    if (go && (cmd == CMD_LMR)) begin
      mode_next = pins_reg.addr; // RULE16
    end
    if (xfer) begin
      bsel_next = bank_cur;
      col_next = col_cur;
      wdat_next = dq_reg;
      wmsk_next = dm_bits; // RULE8
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pwr_reg <= PWR_RUN;
      buf_reg <= 1'b1;
      act_reg <= 1'b0;
      pre_reg <= 1'b0;
      all_reg <= 1'b0;
      ref_reg <= 1'b0;
      apl_reg <= 1'b0;
      bsel_reg <= '0;
      row_reg <= '0;
      mode_reg <= MODE_RST;
      col_reg <= '0;
      wen_reg <= 1'b0;
      ren_reg <= 1'b0;
      wdat_reg <= '0;
      wmsk_reg <= '0;
      mdly_reg <= '0;
      dqo_reg <= '0;
      oe_reg <= '0;
    end else begin
      pwr_reg <= pwr_next;
      buf_reg <= buf_next;
      act_reg <= act_next;
      pre_reg <= pre_next;
      all_reg <= all_next;
      ref_reg <= ref_next;
      apl_reg <= apl_next;
      bsel_reg <= bsel_next;
      row_reg <= row_next;
      mode_reg <= mode_next;
      col_reg <= col_next;
      wen_reg <= wen_next;
      ren_reg <= ren_next;
      wdat_reg <= wdat_next;
      wmsk_reg <= wmsk_next;
      mdly_reg <= mdly_next;
      dqo_reg <= dqo_next;
      oe_reg <= oe_next;
    end
  end

  assign power_state = pwr_reg;
  assign input_buf_en = buf_reg;
  assign act_pulse = act_reg;
  assign pre_pulse = pre_reg;
  assign pre_all = all_reg;
  assign refresh_pulse = ref_reg;
  assign auto_pre_pulse = apl_reg;
  assign bank_sel = bsel_reg;
  assign row_addr = row_reg;
  assign col_addr = COL_W_X4'(col_reg);
  assign mode_word = mode_reg;
  assign array_wr_en = wen_reg;
  assign array_wr_data = wdat_reg;
  assign array_wr_mask = wmsk_reg;
  assign array_rd_en = ren_reg;
  assign dq_out = dqo_reg;
  assign dq_oe = oe_reg;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  sequence s_rd_masked;
    ren_next && (dm_bits == '1) ##1 1'b1;
  endsequence

  sequence s_bl2_read;
    go && (cmd == CMD_RD) && (mode_reg[MODE_BL_LSB +: 3] == BL_2) ##1 go && (cmd == CMD_NOP);
  endsequence

  chk_pin_capture: assert property (buf_on |=> pins_reg.addr == $past(addr)) // RULE1
    else $error("address pins not registered");
  chk_cs_masking: assert property (pins_reg.cs_n |=> !act_reg && !pre_reg && !ref_reg) // RULE5
    else $error("command decoded with chip select high");
  chk_burst_continue: assert property (busy && go && pins_reg.cs_n |=> wen_reg || ren_reg) // RULE6
    else $error("burst stalled by chip select");
  chk_write_mask: assert property (go && cmd == CMD_WR |=> wen_reg && wmsk_reg == $past(dm_bits)) // RULE8
    else $error("write mask not applied");
  chk_read_hiz: assert property (s_rd_masked |=> oe_reg == '0) // RULE9
    else $error("masked read still driven");
  chk_suspend_hold: assert property (pwr_reg == PWR_SUSPEND && !cke_reg |=> $stable(beat) && !wen_reg) // RULE2
    else $error("burst advanced in clock suspend");
  chk_powerdown_exit: assert property (pwr_reg == PWR_DOWN && cke |=> pwr_reg == PWR_RUN && buf_reg) // RULE3
    else $error("power-down not left on clock enable");
  chk_buffers_off: assert property (pwr_reg == PWR_SELFREF && !cke |=> $stable(pins_reg) && !buf_reg) // RULE4
    else $error("inputs captured in self refresh");
  chk_row_bank: assert property (go && cmd == CMD_ACT |=> act_reg && row_reg == $past(pins_reg.addr)
                                 && bsel_reg == $past(pins_reg.ba)) // RULE12
    else $error("row or bank not taken on activate");
  chk_column_pick: assert property (go && cmd == CMD_RD |=> ren_reg && col_reg == $past(col_now)) // RULE13
    else $error("column not taken on read");
  chk_precharge_all: assert property (go && cmd == CMD_PRE |=> pre_reg
                                      && all_reg == $past(pins_reg.addr[PRECHARGE_SELECT_BIT])) // RULE15
    else $error("precharge select ignored");
  chk_auto_precharge: assert property (go && cmd == CMD_WR && pins_reg.addr[PRECHARGE_SELECT_BIT]
                                       && mode_reg[MODE_BL_LSB +: 3] == BL_1 |=> apl_reg) // RULE14
    else $error("auto precharge missing");
  chk_mode_load: assert property (go && cmd == CMD_LMR |=> mode_reg == $past(pins_reg.addr)) // RULE16
    else $error("mode word not stored");
  chk_burst_two: assert property (s_bl2_read |=> !busy ##0 ren_reg) // RULE19
    else $error("two-beat burst length wrong");

endmodule : sdram_pin_command_interface

/* hw/sdram_pkg.sv */
package sdram_pkg;

  // ==========================================================================
  // Widths and organisations
  localparam int ADDR_W = 12;
  localparam int BA_W = 2;
  localparam int DQ_X4 = 4;
  localparam int DQ_X8 = 8;
  localparam int DQ_X16 = 16;
  localparam int COL_W_X4 = 11;
  localparam int COL_W_X8 = 10;
  localparam int COL_W_X16 = 9;
  localparam int LOW_BYTE_W = 8;
  localparam int COL_TOP_BIT_X4 = 11;
  localparam int PRECHARGE_SELECT_BIT = 10;

  // ==========================================================================
  // Mode word fields and burst length codes
  localparam int MODE_BL_LSB = 0;
  localparam logic [ADDR_W-1:0] MODE_RST = 12'h000;
  localparam logic [2:0] BL_1 = 3'h0;
  localparam logic [2:0] BL_2 = 3'h1;
  localparam logic [2:0] BL_4 = 3'h2;
  localparam logic [2:0] BL_8 = 3'h3;
  localparam logic [2:0] BL_PAGE = 3'h7;

  // ==========================================================================
  // Timing
  localparam int MASK_RD_LATENCY = 2;

  // ==========================================================================
  // Types
  typedef enum logic [2:0] {
    CMD_LMR = 3'b000,
    CMD_REF = 3'b001,
    CMD_PRE = 3'b010,
    CMD_ACT = 3'b011,
    CMD_WR = 3'b100,
    CMD_RD = 3'b101,
    CMD_BST = 3'b110,
    CMD_NOP = 3'b111
  } cmd_t;

  typedef enum logic [1:0] {
    PWR_RUN = 2'b00,
    PWR_SUSPEND = 2'b01,
    PWR_DOWN = 2'b10,
    PWR_SELFREF = 2'b11
  } pwr_t;

  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic dml;
    logic dmh;
    logic [BA_W-1:0] ba;
    logic [ADDR_W-1:0] addr;
  } pins_t;

  localparam pins_t PINS_RST = '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
                                 dml: 1'b0, dmh: 1'b0, ba: '0, addr: '0};

  function automatic int col_width(input int dq_w);
    col_width = (dq_w == DQ_X4) ? COL_W_X4 : (dq_w == DQ_X8) ? COL_W_X8 : COL_W_X16;
  endfunction : col_width

endpackage : sdram_pkg

/* hw/sdram_burst_ctr.sv */
`timescale 1ns/10ps
module sdram_burst_ctr #(
  parameter int COL_W = 9
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic load,
  input wire logic advance,
  input wire logic stop,
  input wire logic page,
  input wire logic [COL_W-1:0] limit,
  output logic busy,
  output logic [COL_W-1:0] beat
);

  logic busy_reg, busy_next;
  logic [COL_W-1:0] beat_reg, beat_next;

  // ==========================================================================
  // Beat counter
  // The load cycle carries beat zero itself, so the counter starts at one.
  always_comb begin
    busy_next = busy_reg;
    beat_next = beat_reg;
    if (stop) begin
      busy_next = 1'b0;
    end else if (load) begin
      beat_next = COL_W'(1);
      busy_next = page | (limit != '0);
    end else if (busy_reg && advance) begin
      beat_next = COL_W'(beat_reg + COL_W'(1));
      busy_next = page | (beat_reg != limit);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      busy_reg <= 1'b0;
      beat_reg <= '0;
    end else begin
      busy_reg <= busy_next;
      beat_reg <= beat_next;
    end
  end

  assign busy = busy_reg;
  assign beat = beat_reg;

endmodule : sdram_burst_ctr

/* verif/sdram_ctrl_model.sv */
`timescale 1ns/10ps
module sdram_ctrl_model
  import sdram_pkg::*;
(
  input wire logic ref_clk,
  output logic cke,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic data_mask_low_byte,
  output logic data_mask_high_byte,
  output logic [BA_W-1:0] ba,
  output logic [ADDR_W-1:0] addr,
  output logic [DQ_X16-1:0] dq_in
);
  // ==========================================================================
  // Pin driver
  initial begin
    cke = 1'b1;
    cs_n = 1'b1;
    {ras_n, cas_n, we_n} = 3'b111;
    {data_mask_low_byte, data_mask_high_byte} = 2'b00;
    ba = 2'h0;
    addr = 12'h000;
    dq_in = 16'h0000;
  end

  // One command cycle; bank, address and mask travel with the strobes.
  task automatic send(input cmd_t c, input logic [1:0] b, input logic [11:0] a,
                      input logic dl, input logic dh, input logic [15:0] d, input logic k);
    @(posedge ref_clk);
    #1;
    cs_n = 1'b0;
    {ras_n, cas_n, we_n} = c;
    ba = b;
    addr = a;
    data_mask_low_byte = dl;
    data_mask_high_byte = dh;
    dq_in = d;
    cke = k;
  endtask : send

  // A full command whose chip select is high, so the device must ignore it.
  task automatic masked(input cmd_t c, input logic [1:0] b, input logic [11:0] a);
    @(posedge ref_clk);
    #1;
    cs_n = 1'b1;
    {ras_n, cas_n, we_n} = c;
    ba = b;
    addr = a;
  endtask : masked

  // Deselected cycle: stale strobes, address and data are turned round so they never look held.
  task automatic idle(input logic dl, input logic dh, input logic k);
    @(posedge ref_clk);
    #1;
    cs_n = 1'b1;
    {ras_n, cas_n, we_n} = ~{ras_n, cas_n, we_n};
    addr = ~addr;
    ba = ~ba;
    dq_in = ~dq_in;
    data_mask_low_byte = dl;
    data_mask_high_byte = dh;
    cke = k;
  endtask : idle
endmodule : sdram_ctrl_model

/* verif/sdram_pin_command_interface_tb.sv */
`timescale 1ns/10ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin num_errors++; \
  $display("[ERR] %0t mismatch got %h exp %h", $time, (a), (b)); end end
module sdram_pin_command_interface_tb;
  import sdram_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  int num_errors = 0;
  int tests_run = 0;
  int cyc = 0;
  logic cke, cs_n, ras_n, cas_n, we_n, dml, dmh;
  logic [1:0] ba;
  logic [11:0] addr;
  logic [15:0] dq_in, dq_out, dq_oe, array_rd_data, wr_data, wr_mask;
  pwr_t power_state;
  logic input_buf_en, act_pulse, pre_pulse, pre_all, refresh_pulse, auto_pre_pulse, wr_en, rd_en;
  logic [1:0] bank_sel;
  logic [11:0] row_addr, mode_word;
  logic [10:0] col_addr;

  // The storage array answers with its own column number.
  assign array_rd_data = {5'h00, col_addr};

  sdram_ctrl_model ctrl (.ref_clk(ref_clk), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
    .we_n(we_n), .data_mask_low_byte(dml), .data_mask_high_byte(dmh), .ba(ba), .addr(addr), .dq_in(dq_in));

  sdram_pin_command_interface #(.DQ_W(DQ_X16)) dut (.ref_clk(ref_clk), .rst(rst), .cke(cke), .cs_n(cs_n),
    .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .data_mask_low_byte(dml), .data_mask_high_byte(dmh),
    .ba(ba), .addr(addr), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .array_rd_data(array_rd_data),
    .power_state(power_state), .input_buf_en(input_buf_en), .act_pulse(act_pulse), .pre_pulse(pre_pulse),
    .pre_all(pre_all), .refresh_pulse(refresh_pulse), .auto_pre_pulse(auto_pre_pulse), .bank_sel(bank_sel),
    .row_addr(row_addr), .col_addr(col_addr), .mode_word(mode_word), .array_wr_en(wr_en),
    .array_wr_data(wr_data), .array_wr_mask(wr_mask), .array_rd_en(rd_en));

  // ==========================================================================
  // Clock, timeout and verdict
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic print_verdict();
    $display("errors %0d of %0d comparisons", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : print_verdict

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 2000) begin
      num_errors++;
      print_verdict();
    end
  end

  task automatic edges(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : edges

  // ==========================================================================
  // Scenarios
  task automatic t_activate();
    ctrl.send(CMD_ACT, 2'h2, 12'ha5c, 1'b0, 1'b0, 16'h0000, 1'b1);
    ctrl.idle(1'b0, 1'b0, 1'b1);
    edges(1);
    `CHK(act_pulse, 1'b1)
    `CHK(row_addr, 12'ha5c)
    `CHK(bank_sel, 2'h2)
    edges(1);
    `CHK(act_pulse, 1'b0)
  endtask : t_activate

  task automatic t_cs_masked();
    ctrl.masked(CMD_ACT, 2'h1, 12'h3c3);
    ctrl.idle(1'b0, 1'b0, 1'b1);
    edges(1);
    `CHK(act_pulse, 1'b0)
    `CHK(row_addr, 12'ha5c)
    `CHK(bank_sel, 2'h2)
  endtask : t_cs_masked

  task automatic t_mode();
    ctrl.send(CMD_LMR, 2'h0, {9'h000, BL_2}, 1'b0, 1'b0, 16'h0000, 1'b1);
    ctrl.idle(1'b0, 1'b0, 1'b1);
    edges(1);
    `CHK(mode_word, {9'h000, BL_2})
  endtask : t_mode

  // Two-beat read; second beat runs deselected with the other byte masked.
  task automatic t_read();
    ctrl.send(CMD_RD, 2'h2, 12'h004, 1'b1, 1'b0, 16'h0000, 1'b1);
    ctrl.idle(1'b0, 1'b1, 1'b1);
    edges(1);
    `CHK(rd_en, 1'b1)
    `CHK(col_addr, 11'h004)
    edges(1);
    `CHK(rd_en, 1'b1)
    `CHK(col_addr, 11'h005)
    `CHK(dq_out, 16'h0004)
    `CHK(dq_oe, 16'hff00)
    edges(1);
    `CHK(rd_en, 1'b0)
    `CHK(dq_out, 16'h0005)
    `CHK(dq_oe, 16'h00ff)
    edges(1);
    `CHK(dq_oe, 16'h0000)
  endtask : t_read

  task automatic t_write();
    ctrl.send(CMD_WR, 2'h2, 12'h403, 1'b0, 1'b1, 16'h1234, 1'b1);
    ctrl.idle(1'b0, 1'b0, 1'b1);
    edges(1);
    `CHK(wr_en, 1'b1)
    `CHK(wr_data, 16'h1234)
    `CHK(wr_mask, 16'hff00)
    `CHK(col_addr, 11'h003)
    `CHK(auto_pre_pulse, 1'b0)
    edges(1);
    `CHK(wr_en, 1'b1)
    `CHK(wr_data, 16'hedcb)
    `CHK(wr_mask, 16'h0000)
    `CHK(col_addr, 11'h002)
    `CHK(auto_pre_pulse, 1'b1)
    edges(1);
  endtask : t_write

  task automatic t_precharge();
    ctrl.send(CMD_PRE, 2'h3, 12'h400, 1'b0, 1'b0, 16'h0000, 1'b1);
    ctrl.send(CMD_PRE, 2'h1, 12'h000, 1'b0, 1'b0, 16'h0000, 1'b1);
    ctrl.idle(1'b0, 1'b0, 1'b1);
    `CHK(pre_pulse, 1'b1)
    `CHK(pre_all, 1'b1)
    edges(1);
    `CHK(pre_pulse, 1'b1)
    `CHK(pre_all, 1'b0)
    `CHK(bank_sel, 2'h1)
  endtask : t_precharge

  task automatic t_power();
    ctrl.idle(1'b0, 1'b0, 1'b0);
    edges(2);
    `CHK(power_state, PWR_DOWN)
    `CHK(input_buf_en, 1'b0)
    ctrl.idle(1'b0, 1'b0, 1'b1);
    edges(2);
    `CHK(power_state, PWR_RUN)
    `CHK(input_buf_en, 1'b1)
    ctrl.send(CMD_REF, 2'h0, 12'h000, 1'b0, 1'b0, 16'h0000, 1'b0);
    ctrl.idle(1'b0, 1'b0, 1'b0);
    edges(1);
    `CHK(power_state, PWR_SELFREF)
    ctrl.idle(1'b0, 1'b0, 1'b1);
    edges(2);
    `CHK(power_state, PWR_RUN)
    ctrl.send(CMD_REF, 2'h0, 12'h000, 1'b0, 1'b0, 16'h0000, 1'b1);
    ctrl.idle(1'b0, 1'b0, 1'b1);
    edges(1);
    `CHK(refresh_pulse, 1'b1)
    `CHK(power_state, PWR_RUN)
  endtask : t_power

  initial begin
    edges(10);
    rst = 1'b0;
    edges(2);
    t_activate();
    t_cs_masked();
    t_mode();
    t_read();
    t_write();
    t_precharge();
    t_power();
    print_verdict();
  end
endmodule : sdram_pin_command_interface_tb
